// >>> include/or_exec_pkg.sv
package or_exec_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath and bus widths
    localparam int DATA_W     = 8;
    localparam int BANK_W     = 4;
    localparam int FADDR_W    = 12;
    localparam int OPC_W      = 16;
    localparam int AXI_ADDR_W = 8;
    localparam int AXI_DATA_W = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction encoding
    localparam logic [7:0]  OPC_LIT_HI = 8'h09;
    localparam logic [5:0]  OPC_REG_HI = 6'h04;
    localparam int          OPC_D_BIT  = 9;
    localparam int          OPC_A_BIT  = 8;

    // Access bank split: low part of bank 0 or, if enabled, indexed window
    localparam logic [7:0]        ACCESS_LIMIT   = 8'h5F;
    localparam logic [BANK_W-1:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [BANK_W-1:0] ACCESS_HI_BANK = 4'hF;

    ////////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [AXI_ADDR_W-1:0] OFS_INSTR   = 8'h00;
    localparam logic [AXI_ADDR_W-1:0] OFS_WREG    = 8'h04;
    localparam logic [AXI_ADDR_W-1:0] OFS_BANK    = 8'h08;
    localparam logic [AXI_ADDR_W-1:0] OFS_CTRL    = 8'h0C;
    localparam logic [AXI_ADDR_W-1:0] OFS_STATUS  = 8'h10;
    localparam logic [AXI_ADDR_W-1:0] OFS_INDEX   = 8'h14;
    localparam logic [AXI_ADDR_W-1:0] OFS_MEMADDR = 8'h18;
    localparam logic [AXI_ADDR_W-1:0] OFS_MEMDATA = 8'h1C;

    localparam int CTRL_EXT_BIT    = 0;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_ZERO_BIT     = 1;
    localparam int ST_NEG_BIT      = 2;
    localparam int ST_ILLEGAL_BIT  = 3;

    localparam logic [DATA_W-1:0]  W_RESET     = 8'h00;
    localparam logic [BANK_W-1:0]  BANK_RESET  = 4'h0;
    localparam logic [FADDR_W-1:0] INDEX_RESET = 12'h000;
    localparam logic [OPC_W-1:0]   OPC_RESET   = 16'h0000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_READ = 2'b01,
        ST_EXEC = 2'b10
    } exec_state_t;

endpackage

// >>> core/file_ram.sv
`timescale 1ns/1ps
module file_ram #(
    parameter int ADDR_W = 12,
    parameter int DATA_W = 8
) (
    // Clocking
    input  wire logic              clock,
    input  wire logic              clkEn,
    // Single port
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              we,
    input  wire logic [DATA_W-1:0] wdata,
    output logic      [DATA_W-1:0] rdataQ
);

    logic [DATA_W-1:0] mem [2**ADDR_W];

    // No reset on the array; read data is registered, one cycle after addr
    always_ff @(posedge clock) begin
        if (clkEn) begin
            if (we) begin
                mem[addr] <= wdata;
            end
            rdataQ <= mem[addr];
        end
    end

endmodule // file_ram

// >>> core/inclusive_or_exec_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - register-form opcode 000100da ffffffff ORs accumulator with addressed file byte.
// - destination bit 0 puts the result in the accumulator, file byte untouched.
// - destination bit 1 writes the result back into the addressed file byte.
// - access bit 0 uses the access bank; 1 uses bank_select_pointer for the bank.
// - access bit 0, extended set on, address at most 5Fh: indexed literal offset.
module inclusive_or_exec_unit
    import or_exec_pkg::*;
(
    // Clock and reset
    input  wire logic                  clock,
    input  wire logic                  arst_n,
    input  wire logic                  clkEn,
    // AXI4-Lite write address and data
    input  wire logic                  awvalid,
    output logic                       awready,
    input  wire logic [AXI_ADDR_W-1:0] awaddr,
    input  wire logic                  wvalid,
    output logic                       wready,
    input  wire logic [AXI_DATA_W-1:0] wdata,
    input  wire logic [3:0]            wstrb,
    // AXI4-Lite write response
    output logic                       bvalid,
    input  wire logic                  bready,
    output logic [1:0]                 bresp,
    // AXI4-Lite read
    input  wire logic                  arvalid,
    output logic                       arready,
    input  wire logic [AXI_ADDR_W-1:0] araddr,
    output logic                       rvalid,
    input  wire logic                  rready,
    output logic [AXI_DATA_W-1:0]      rdata,
    output logic [1:0]                 rresp
);

    ////////////////////////////////////////////////////////////////////////////////
    // State
    exec_state_t         stateQ;
    logic [DATA_W-1:0]   wQ;
    logic [BANK_W-1:0]   bankQ;
    logic                extEnQ;
    logic [FADDR_W-1:0]  indexQ;
    logic [FADDR_W-1:0]  memAddrRegQ;
    logic [OPC_W-1:0]    opcodeQ;
    logic [FADDR_W-1:0]  execAddrQ;
    logic                zeroQ;
    logic                negQ;
    logic                illegalQ;
    logic                rdPendQ;
    logic                busy;

    logic [DATA_W-1:0]   memRdata;
    logic [FADDR_W-1:0]  memAddr;
    logic                memWe;
    logic [DATA_W-1:0]   memWdata;
    logic [DATA_W-1:0]   orRes;

    assign busy = (stateQ != ST_IDLE);

    function automatic logic [AXI_DATA_W-1:0] mergeStrb(input logic [AXI_DATA_W-1:0] old,
                                                       input logic [AXI_DATA_W-1:0] nw,
                                                       input logic [3:0]            strb);
        logic [AXI_DATA_W-1:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Write channel: both beats taken together, in the cycle after both are valid
    logic wrFire;
    logic wrMapped;
    logic wrRefused;
    logic startAny;
    logic startLit;
    logic startReg;
    logic [OPC_W-1:0] newOpc;
    logic [7:0]       fAddr;

    assign wrFire    = awready;
    assign newOpc    = wdata[OPC_W-1:0];
    assign fAddr     = newOpc[7:0];
    assign wrMapped  = (awaddr == OFS_INSTR) || (awaddr == OFS_WREG) || (awaddr == OFS_BANK)
                    || (awaddr == OFS_CTRL) || (awaddr == OFS_INDEX) || (awaddr == OFS_MEMADDR)
                    || (awaddr == OFS_MEMDATA) || (awaddr == OFS_STATUS);
    // Executing owns the file port, so instruction and file writes are refused with SLVERR until idle
    assign wrRefused = !wrMapped || (busy && ((awaddr == OFS_INSTR) || (awaddr == OFS_MEMDATA)));
    assign startAny  = clkEn && wrFire && !wrRefused && (awaddr == OFS_INSTR) && (wstrb[1:0] == 2'b11);
    assign startLit  = startAny && (newOpc[15:8] == OPC_LIT_HI);
    assign startReg  = startAny && (newOpc[15:10] == OPC_REG_HI);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= RESP_OKAY;
        end else if (clkEn) begin
            awready <= awvalid && wvalid && !awready && !bvalid;
            wready  <= awvalid && wvalid && !awready && !bvalid;
            if (wrFire) begin
                bvalid <= 1'b1;
                bresp  <= wrRefused ? RESP_SLVERR : RESP_OKAY;
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration registers written by software
    logic [AXI_DATA_W-1:0] bankMerge;
    logic [AXI_DATA_W-1:0] indexMerge;
    logic [AXI_DATA_W-1:0] memAddrMerge;

    assign bankMerge    = mergeStrb({28'h0000000, bankQ}, wdata, wstrb);
    assign indexMerge   = mergeStrb({20'h00000, indexQ}, wdata, wstrb);
    assign memAddrMerge = mergeStrb({20'h00000, memAddrRegQ}, wdata, wstrb);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            bankQ       <= BANK_RESET;
            extEnQ      <= 1'b0;
            indexQ      <= INDEX_RESET;
            memAddrRegQ <= INDEX_RESET;
        end else if (clkEn && wrFire && !wrRefused) begin
            case (awaddr)
                OFS_BANK:    bankQ       <= bankMerge[BANK_W-1:0];
                OFS_CTRL:    extEnQ      <= wstrb[0] ? wdata[CTRL_EXT_BIT] : extEnQ;
                OFS_INDEX:   indexQ      <= indexMerge[FADDR_W-1:0];
                OFS_MEMADDR: memAddrRegQ <= memAddrMerge[FADDR_W-1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Execution sequencer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            stateQ    <= ST_IDLE;
            opcodeQ   <= OPC_RESET;
            execAddrQ <= INDEX_RESET;
            illegalQ  <= 1'b0;
        end else if (clkEn) begin
            case (stateQ)
                ST_IDLE: begin
                    if (startAny) begin
                        opcodeQ  <= newOpc;
                        illegalQ <= !(startLit || startReg);
                    end
                    if (startReg) begin
                        stateQ <= ST_READ;
                        if (newOpc[OPC_A_BIT]) begin
                            execAddrQ <= {bankQ, fAddr};
                        end else if (extEnQ && (fAddr <= ACCESS_LIMIT)) begin
                            execAddrQ <= indexQ + FADDR_W'(fAddr);
                        end else if (fAddr <= ACCESS_LIMIT) begin
                            execAddrQ <= {ACCESS_LO_BANK, fAddr};
                        end else begin
                            execAddrQ <= {ACCESS_HI_BANK, fAddr};
                        end
                    end
                end
                ST_READ: stateQ <= ST_EXEC;
                ST_EXEC: stateQ <= ST_IDLE;
                default: stateQ <= ST_IDLE;
            endcase
        end
    end

    assign orRes = wQ | memRdata;

    // Accumulator and flags
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wQ    <= W_RESET;
            zeroQ <= 1'b0;
            negQ  <= 1'b0;
        end else if (clkEn) begin
            if (startLit) begin
                wQ    <= wQ | fAddr;
                zeroQ <= ((wQ | fAddr) == '0);
                negQ  <= fAddr[DATA_W-1] | wQ[DATA_W-1];
            end else if (stateQ == ST_EXEC) begin
                if (!opcodeQ[OPC_D_BIT]) begin
                    wQ <= orRes;
                end
                zeroQ <= (orRes == '0);
                negQ  <= orRes[DATA_W-1];
            end else if (wrFire && !wrRefused && (awaddr == OFS_WREG) && wstrb[0]) begin
                wQ <= wdata[DATA_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // File memory port: sequencer first, software only while idle
    logic arFire;
    logic arMem;
    assign arFire = arready;
    assign arMem  = arFire && (araddr == OFS_MEMDATA) && !busy;

    always_comb begin
        memAddr  = memAddrRegQ;
        memWe    = 1'b0;
        memWdata = wdata[DATA_W-1:0];
        if (busy) begin
            memAddr  = execAddrQ;
            memWe    = (stateQ == ST_EXEC) && opcodeQ[OPC_D_BIT];
            memWdata = orRes;
        end else if (wrFire && !wrRefused && (awaddr == OFS_MEMDATA) && wstrb[0]) begin
            memWe = 1'b1;
        end
    end

    file_ram #(
        .ADDR_W (FADDR_W),
        .DATA_W (DATA_W)
    ) u_file_ram (
        .clock  (clock),
        .clkEn  (clkEn),
        .addr   (memAddr),
        .we     (memWe),
        .wdata  (memWdata),
        .rdataQ (memRdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Read channel; a file read answers one cycle later than a register read
    logic                  rdMapped;
    logic [AXI_DATA_W-1:0] rdMux;

    always_comb begin
        rdMapped = 1'b1;
        rdMux    = '0;
        case (araddr)
            OFS_INSTR:   rdMux = {16'h0000, opcodeQ};
            OFS_WREG:    rdMux = {24'h000000, wQ};
            OFS_BANK:    rdMux = {28'h0000000, bankQ};
            OFS_CTRL:    rdMux = {31'h0, extEnQ};
            OFS_STATUS:  rdMux = {28'h0000000, illegalQ, negQ, zeroQ, busy};
            OFS_INDEX:   rdMux = {20'h00000, indexQ};
            OFS_MEMADDR: rdMux = {20'h00000, memAddrRegQ};
            OFS_MEMDATA: rdMapped = !busy;
            default:     rdMapped = 1'b0;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= 32'h00000000;
            rresp   <= RESP_OKAY;
            rdPendQ <= 1'b0;
        end else if (clkEn) begin
            arready <= arvalid && !arready && !rvalid && !rdPendQ;
            if (arMem) begin
                rdPendQ <= 1'b1;
            end else if (arFire) begin
                rvalid <= 1'b1;
                rdata  <= rdMux;
                rresp  <= rdMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (rdPendQ) begin
                rdPendQ <= 1'b0;
                rvalid  <= 1'b1;
                rdata   <= {24'h000000, memRdata};
                rresp   <= RESP_OKAY;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    AST_REG_OR_WRITEBACK: assert property (@(posedge clock) disable iff (!arst_n)
        (clkEn && stateQ == ST_EXEC && memWe) |-> (memWdata == (wQ | memRdata)))
        else $error("file write-back is not accumulator OR file byte");

    AST_DEST_W: assert property (@(posedge clock) disable iff (!arst_n)
        (clkEn && stateQ == ST_EXEC && !opcodeQ[OPC_D_BIT]) |-> !memWe ##1 (wQ == ($past(wQ) | $past(memRdata))))
        else $error("destination 0 did not update only the accumulator");

    AST_DEST_FILE: assert property (@(posedge clock) disable iff (!arst_n)
        (clkEn && stateQ == ST_EXEC && opcodeQ[OPC_D_BIT]) |-> (memWe && memAddr == execAddrQ) ##1 $stable(wQ))
        else $error("destination 1 did not write back to the file");

    AST_BANKED_ADDR: assert property (@(posedge clock) disable iff (!arst_n)
        (startReg && newOpc[OPC_A_BIT]) |=> (execAddrQ == {$past(bankQ), $past(fAddr)}) && stateQ == ST_READ)
        else $error("banked operand address wrong");

    AST_ACCESS_ADDR: assert property (@(posedge clock) disable iff (!arst_n)
        (startReg && !newOpc[OPC_A_BIT] && (!extEnQ || fAddr > ACCESS_LIMIT))
            |=> execAddrQ[7:0] == $past(fAddr)
             && execAddrQ[FADDR_W-1:8] == ($past(fAddr) > ACCESS_LIMIT ? ACCESS_HI_BANK : ACCESS_LO_BANK))
        else $error("access bank operand address wrong");

    AST_INDEXED_ADDR: assert property (@(posedge clock) disable iff (!arst_n)
        (startReg && !newOpc[OPC_A_BIT] && extEnQ && fAddr <= ACCESS_LIMIT)
            |=> (execAddrQ == $past(indexQ) + FADDR_W'($past(fAddr))))
        else $error("indexed operand address wrong");

    AST_LITERAL_ONE_CYCLE: assert property (@(posedge clock) disable iff (!arst_n)
        startLit |=> (wQ == ($past(wQ) | $past(fAddr))) && (zeroQ == (wQ == '0)) && (negQ == wQ[DATA_W-1])
                     && stateQ == ST_IDLE)
        else $error("literal OR result or flags wrong");

    AST_REG_LATENCY: assert property (@(posedge clock) disable iff (!arst_n)
        (startReg ##1 clkEn[*2]) |=> (stateQ == ST_IDLE && zeroQ == (($past(wQ, 2) | $past(memRdata)) == '0)))
        else $error("register-form instruction did not finish in three cycles");

    COV_LITERAL: cover property (@(posedge clock) disable iff (!arst_n) startLit);
    COV_REG_TO_FILE: cover property (@(posedge clock) disable iff (!arst_n)
        clkEn && stateQ == ST_EXEC && memWe);
    COV_INDEXED: cover property (@(posedge clock) disable iff (!arst_n)
        startReg && !newOpc[OPC_A_BIT] && extEnQ && fAddr <= ACCESS_LIMIT);
    COV_BUSY_REFUSE: cover property (@(posedge clock) disable iff (!arst_n)
        arFire && busy && araddr == OFS_MEMDATA);

endmodule // inclusive_or_exec_unit

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    import or_exec_pkg::*;

    logic                  clock;
    logic                  arst_n;
    logic                  clkEn;
    logic                  awvalid, awready, wvalid, wready, bvalid, bready;
    logic [AXI_ADDR_W-1:0] awaddr, araddr;
    logic [AXI_DATA_W-1:0] wdata, rdata;
    logic [3:0]            wstrb;
    logic [1:0]            bresp, rresp;
    logic                  arvalid, arready, rvalid, rready;
    int                    failures;
    int                    nCompared;

    inclusive_or_exec_unit dut (
        .clock(clock), .arst_n(arst_n), .clkEn(clkEn),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checking and closing
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("mismatches %0d comparisons %0d", failures, nCompared);
        if (failures == 0 && nCompared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Bus master; each task starts one edge later so releases never collide
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] expResp);
        int n;
        n = 0;
        @(posedge clock);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge clock);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, expResp}, {30'h0, bresp});
                break;
            end
            if (n > 200) begin
                failures++;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        n = 0;
        d = 32'hFFFF_FFFF;
        resp = 2'h3;
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge clock);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                d = rdata;
                resp = rresp;
                break;
            end
            if (n > 200) begin
                failures++;
                break;
            end
        end
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(nm, exp, d);
        chk("rresp", {30'h0, er}, {30'h0, r});
    endtask

    task automatic mem_wr(input logic [11:0] m, input logic [7:0] v);
        wr(OFS_MEMADDR, {20'h0, m}, RESP_OKAY);
        wr(OFS_MEMDATA, {24'h0, v}, RESP_OKAY);
    endtask

    task automatic mem_chk(input logic [11:0] m, input logic [7:0] v);
        wr(OFS_MEMADDR, {20'h0, m}, RESP_OKAY);
        rd_chk("file byte", OFS_MEMDATA, {24'h0, v}, RESP_OKAY);
    endtask

    // Register-form execution lasts a few cycles; poll busy instead of assuming a count
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0]  r;
        for (int i = 0; i < 20; i++) begin
            rd(OFS_STATUS, d, r);
            if (d[ST_BUSY_BIT] === 1'b0) break;
        end
        chk("busy cleared", 32'h0, {31'h0, d[ST_BUSY_BIT]});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        // File array has no reset, so byte 0 gets a known value before it is read back
        mem_wr(12'h000, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset value", 8'(i * 4), 32'h0, RESP_OKAY);
        end
        rd_chk("unmapped read", 8'h20, 32'h0, RESP_SLVERR);
        wr(8'h24, 32'h0000_00FF, RESP_SLVERR);
    endtask

    task automatic t_literal();
        wr(OFS_WREG, 32'h0000_009A, RESP_OKAY);
        wr(OFS_INSTR, 32'h0000_0935, RESP_OKAY);
        rd_chk("literal result", OFS_WREG, 32'h0000_00BF, RESP_OKAY);
        rd_chk("literal flags", OFS_STATUS, 32'h0000_0004, RESP_OKAY);
        wr(OFS_WREG, 32'h0000_0000, RESP_OKAY);
        wr(OFS_INSTR, 32'h0000_0900, RESP_OKAY);
        rd_chk("literal zero", OFS_STATUS, 32'h0000_0002, RESP_OKAY);
    endtask

    task automatic run_reg(input logic [11:0] m, input logic [7:0] mv, input logic [7:0] w, input logic [15:0] op,
                           input logic [7:0] expW, input logic [7:0] expM, input logic [31:0] expSt);
        mem_wr(m, mv);
        wr(OFS_WREG, {24'h0, w}, RESP_OKAY);
        wr(OFS_INSTR, {16'h0, op}, RESP_OKAY);
        wait_idle();
        rd_chk("accumulator", OFS_WREG, {24'h0, expW}, RESP_OKAY);
        mem_chk(m, expM);
        rd_chk("flags", OFS_STATUS, expSt, RESP_OKAY);
    endtask

    task automatic t_reg_to_w();
        wr(OFS_BANK, 32'h0000_0003, RESP_OKAY);
        run_reg(12'h313, 8'h13, 8'h91, 16'h1113, 8'h93, 8'h13, 32'h4);
    endtask

    task automatic t_reg_to_file();
        run_reg(12'h05F, 8'h40, 8'h01, 16'h125F, 8'h01, 8'h41, 32'h0);
        run_reg(12'hF80, 8'h30, 8'h0F, 16'h1380 & 16'h12FF, 8'h0F, 8'h3F, 32'h0);
    endtask

    task automatic t_indexed();
        wr(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
        wr(OFS_INDEX, 32'h0000_0200, RESP_OKAY);
        run_reg(12'h25F, 8'h00, 8'h00, 16'h125F, 8'h00, 8'h00, 32'h2);
        mem_chk(12'h05F, 8'h41);
        run_reg(12'hF60, 8'h0F, 8'h30, 16'h1260, 8'h30, 8'h3F, 32'h0);
    endtask

    task automatic t_illegal();
        wr(OFS_INSTR, 32'h0000_FFFF, RESP_OKAY);
        rd_chk("illegal flag", OFS_STATUS, 32'h0000_0008, RESP_OKAY);
        rd_chk("last opcode", OFS_INSTR, 32'h0000_FFFF, RESP_OKAY);
        rd_chk("accumulator kept", OFS_WREG, 32'h0000_0030, RESP_OKAY);
    endtask

    task automatic t_busy_and_freeze();
        mem_wr(12'h3A0, 8'h05);
        wr(OFS_WREG, 32'h0000_0001, RESP_OKAY);
        // A file read one cycle behind the instruction lands while the sequencer owns the port
        fork
            wr(OFS_INSTR, 32'h0000_11A0, RESP_OKAY);
            begin
                @(posedge clock);
                rd_chk("busy file read", OFS_MEMDATA, 32'h0, RESP_SLVERR);
            end
        join
        rd_chk("accumulator", OFS_WREG, 32'h0000_0005, RESP_OKAY);
        wr(OFS_WREG, 32'h0000_0040, RESP_OKAY);
        wr(OFS_INSTR, 32'h0000_11A0, RESP_OKAY);
        // Enable drops in the execute cycle; a pending read request must wait as well
        clkEn   <= 1'b0;
        araddr  <= OFS_STATUS;
        arvalid <= 1'b1;
        repeat (5) @(posedge clock);
        chk("frozen arready", 32'h0, {31'h0, arready});
        clkEn <= 1'b1;
        rd_chk("status after freeze", OFS_STATUS, 32'h0, RESP_OKAY);
        rd_chk("frozen result", OFS_WREG, 32'h0000_0045, RESP_OKAY);
        mem_chk(12'h3A0, 8'h05);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        failures  = 0;
        nCompared = 0;
        arst_n  = 1'b0;
        clkEn   = 1'b1;
        awvalid = 1'b0;
        wvalid  = 1'b0;
        bready  = 1'b0;
        arvalid = 1'b0;
        rready  = 1'b0;
        awaddr  = 8'h00;
        araddr  = 8'h00;
        wdata   = 32'h0;
        wstrb   = 4'h0;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        t_reset();
        t_literal();
        t_reg_to_w();
        t_reg_to_file();
        t_indexed();
        t_illegal();
        t_busy_and_freeze();
        end_sim();
    end

    // Whole run needs a few hundred cycles; this span is generous
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        end_sim();
    end

endmodule // tb
